// *** hdl/vga_rw_pkg.sv ***
// Constants for the byte-to-plane read/write datapath
`default_nettype none
package vga_rw_pkg;
  localparam int          REG_AW     = 8;
  // Register byte offsets
  localparam logic [7:0]  OFF_MODE   = 8'h00;
  localparam logic [7:0]  OFF_ROT    = 8'h04;
  localparam logic [7:0]  OFF_FILL   = 8'h08;
  localparam logic [7:0]  OFF_MASK   = 8'h0c;
  localparam logic [7:0]  OFF_MATCH  = 8'h10;
  localparam logic [7:0]  OFF_LATCH  = 8'h14;
  localparam logic [7:0]  OFF_STATUS = 8'h18;
  // Writable bits per register
  localparam logic [31:0] WMASK_MODE  = 32'h0000_003f;
  localparam logic [31:0] WMASK_ROT   = 32'h0000_001f;
  localparam logic [31:0] WMASK_FILL  = 32'h0000_00ff;
  localparam logic [31:0] WMASK_MASK  = 32'h0000_0fff;
  localparam logic [31:0] WMASK_MATCH = 32'h0000_03ff;
  // Reset values
  localparam logic [31:0] RST_MODE  = 32'h0000_0000;
  localparam logic [31:0] RST_ROT   = 32'h0000_0000;
  localparam logic [31:0] RST_FILL  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK  = 32'h0000_0fff;
  localparam logic [31:0] RST_MATCH = 32'h0000_0000;
  // Field positions: mode register
  localparam int MODE_WM_LSB    = 0;
  localparam int MODE_RM_BIT    = 2;
  localparam int MODE_CHAIN4    = 3;
  localparam int MODE_ODDEVEN   = 4;
  localparam int MODE_PAGE_BIT  = 5;
  // Rotation control register
  localparam int ROT_AMT_LSB    = 0;
  localparam int ROT_ALU_LSB    = 3;
  // Fill register: value low nibble, select high nibble
  localparam int FILL_VAL_LSB   = 0;
  localparam int FILL_SEL_LSB   = 4;
  // Mask register: pixel mask byte, plane write enables above
  localparam int MASK_PIX_LSB   = 0;
  localparam int MASK_PWE_LSB   = 8;
  // Match register
  localparam int MATCH_COL_LSB  = 0;
  localparam int MATCH_IGN_LSB  = 4;
  localparam int MATCH_RPC_LSB  = 8;
  // Write modes
  localparam logic [1:0] WM_FILL_OR_HOST = 2'h0;
  localparam logic [1:0] WM_LATCH_COPY   = 2'h1;
  localparam logic [1:0] WM_COLOR        = 2'h2;
  localparam logic [1:0] WM_FILL_MASKED  = 2'h3;
  // Raster functions
  localparam logic [1:0] ALU_COPY = 2'h0;
  localparam logic [1:0] ALU_AND  = 2'h1;
  localparam logic [1:0] ALU_OR   = 2'h2;
  localparam logic [1:0] ALU_XOR  = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// *** hdl/vga_plane_rw_datapath.sv ***
// Byte-to-plane read/write datapath with AXI4-Lite control registers
//
// Notes on behaviour
// - Write byte is rotated right by rotate_amount, zero to seven places.
// - Reads bypass the rotator entirely.
// - Every frame-buffer read loads all 32 bits into the display latch.
// - Mode 0: planes with fill select take fill value, others rotated byte.
// - Mode 1: all 32 bits come from the latch, host byte ignored.
// - Mode 2: host bits 0..3 each replicated across their plane byte.
// - Mode 3: planes filled from fill value; mask is rotated byte AND pixel mask.
// - Read mode 0 returns the byte of the plane chosen by read_plane_choice.
// - Four-plane interleave: address bits 1:0 choose the read plane.
// - Odd/even: address bit 0 replaces low bit of read_plane_choice.
// - Read mode 1: bit n set when every plane bit n equals match_color.
// - Planes flagged in match_plane_ignore always count as matching.
// - Raster ALU offers copy, AND, OR and XOR.
// - ALU operands are write-mode output and display latch.
// - ALU is bypassed in write mode 1.
// - Pixel mask bit n picks ALU output (1) or latch (0) in all planes.
// - Mode 1 applies no pixel mask; latch is written unchanged.
// - Zero pixel mask with copy writes the latch exactly.
// - Host side carries exactly one byte per access.
// - Write plane enables are plane_write_enable ANDed with address enables; reads enable all four planes.
`default_nettype none
module vga_plane_rw_datapath
  import vga_rw_pkg::*;
#(
  parameter int FB_AW = 16
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic [REG_AW-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [REG_AW-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              HOST_REQ,
  input  wire logic              HOST_WE,
  input  wire logic [FB_AW-1:0]  HOST_ADDR,
  input  wire logic [7:0]        HOST_WDATA,
  output logic                   HOST_READY,
  output logic [7:0]             HOST_RDATA,
  output logic                   HOST_RVALID,
  output logic                   FB_REQ,
  output logic                   FB_WE,
  output logic [FB_AW-1:0]       FB_ADDR,
  output logic [3:0]             FB_BE,
  output logic [31:0]            FB_WDATA,
  input  wire logic              FB_GNT,
  input  wire logic              FB_RVALID,
  input  wire logic [31:0]       FB_RDATA
);

  typedef enum logic [1:0] {ST_IDLE, ST_WR_REQ, ST_RD_REQ, ST_RD_WAIT} state_t;

  function automatic logic [7:0] rotr8(input logic [7:0] d, input logic [2:0] r);
    logic [15:0] t;
    t = {d, d} >> r;
    return t[7:0];
  endfunction

  // Each nibble bit spread over its own plane byte
  function automatic logic [31:0] rep_bits(input logic [3:0] v);
    return {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}};
  endfunction

  function automatic logic [31:0] rep_byte(input logic [7:0] v);
    return {4{v}};
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb, input logic [31:0] wm);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wm;
    return (old & ~m) | (nw & m);
  endfunction

  logic [31:0]       mode_q;
  logic [31:0]       rot_q;
  logic [31:0]       fill_q;
  logic [31:0]       mask_q;
  logic [31:0]       match_q;
  logic [31:0]       latch_q;
  state_t            state_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [REG_AW-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              fb_req_q;
  logic              fb_we_q;
  logic [FB_AW-1:0]  fb_addr_q;
  logic [3:0]        fb_be_q;
  logic [31:0]       fb_wdata_q;
  logic [7:0]        host_rdata_q;
  logic              host_rvalid_q;

  // Field views
  logic [1:0] wm;
  logic       rm;
  logic       chain4;
  logic       oddeven;
  logic       page_bit;
  logic [2:0] rot_amt;
  logic [1:0] alu_fn;
  logic [3:0] fill_val;
  logic [3:0] fill_sel;
  logic [7:0] pix_mask;
  logic [3:0] pwe;
  logic [3:0] match_col;
  logic [3:0] match_ign;
  logic [1:0] rpc;

  assign wm        = mode_q[MODE_WM_LSB +: 2];
  assign rm        = mode_q[MODE_RM_BIT];
  assign chain4    = mode_q[MODE_CHAIN4];
  assign oddeven   = mode_q[MODE_ODDEVEN];
  assign page_bit  = mode_q[MODE_PAGE_BIT];
  assign rot_amt   = rot_q[ROT_AMT_LSB +: 3];
  assign alu_fn    = rot_q[ROT_ALU_LSB +: 2];
  assign fill_val  = fill_q[FILL_VAL_LSB +: 4];
  assign fill_sel  = fill_q[FILL_SEL_LSB +: 4];
  assign pix_mask  = mask_q[MASK_PIX_LSB +: 8];
  assign pwe       = mask_q[MASK_PWE_LSB +: 4];
  assign match_col = match_q[MATCH_COL_LSB +: 4];
  assign match_ign = match_q[MATCH_IGN_LSB +: 4];
  assign rpc       = match_q[MATCH_RPC_LSB +: 2];

  // AXI4-Lite slave
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] ar_data;
  logic        ar_ok;

  assign AWREADY = !aw_held_q && !bvalid_q;
  assign WREADY  = !w_held_q && !bvalid_q;
  assign ARREADY = !rvalid_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign RVALID  = rvalid_q;
  assign RRESP   = rresp_q;
  assign RDATA   = rdata_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ok   = (aw_addr_q == OFF_MODE) || (aw_addr_q == OFF_ROT) ||
                   (aw_addr_q == OFF_FILL) || (aw_addr_q == OFF_MASK) ||
                   (aw_addr_q == OFF_MATCH);

  // Address and data may arrive in either order
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_held_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode_q  <= RST_MODE;
      rot_q   <= RST_ROT;
      fill_q  <= RST_FILL;
      mask_q  <= RST_MASK;
      match_q <= RST_MATCH;
    end else if (wr_fire) begin
      case (aw_addr_q)
        OFF_MODE:  mode_q  <= merge_strb(mode_q, w_data_q, w_strb_q, WMASK_MODE);
        OFF_ROT:   rot_q   <= merge_strb(rot_q, w_data_q, w_strb_q, WMASK_ROT);
        OFF_FILL:  fill_q  <= merge_strb(fill_q, w_data_q, w_strb_q, WMASK_FILL);
        OFF_MASK:  mask_q  <= merge_strb(mask_q, w_data_q, w_strb_q, WMASK_MASK);
        OFF_MATCH: match_q <= merge_strb(match_q, w_data_q, w_strb_q, WMASK_MATCH);
        default:   mode_q  <= mode_q;
      endcase
    end
  end

  always_comb begin
    ar_data = '0;
    ar_ok   = 1'b1;
    case (ARADDR)
      OFF_MODE:   ar_data = mode_q;
      OFF_ROT:    ar_data = rot_q;
      OFF_FILL:   ar_data = fill_q;
      OFF_MASK:   ar_data = mask_q;
      OFF_MATCH:  ar_data = match_q;
      OFF_LATCH:  ar_data = latch_q;
      OFF_STATUS: ar_data = {23'h0, host_rdata_q, state_q != ST_IDLE};
      default:    ar_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rresp_q  <= ar_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= ar_data;
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // Write datapath
  logic [7:0]       rot_byte;
  logic [31:0]      wm_out;
  logic [7:0]       eff_mask;
  logic [31:0]      alu_out;
  logic [31:0]      wr_word;
  logic [3:0]       addr_be;
  logic [FB_AW-1:0] fb_addr_d;
  logic             host_take;

  assign host_take  = HOST_REQ && HOST_READY;
  assign HOST_READY = (state_q == ST_IDLE);

  always_comb begin
    // Rotation before write mode
    // rotate right
    rot_byte = rotr8(HOST_WDATA, rot_amt);
    eff_mask = pix_mask;
    wm_out   = '0;
    case (wm)
      WM_FILL_OR_HOST: wm_out = (rep_bits(fill_sel) & rep_bits(fill_val)) |
                                (~rep_bits(fill_sel) & rep_byte(rot_byte));
      WM_LATCH_COPY:   wm_out = latch_q;
      // Colour mode uses the unrotated host nibble
      // bit replication
      WM_COLOR:        wm_out = rep_bits(HOST_WDATA[3:0]);
      WM_FILL_MASKED: begin
        wm_out   = rep_bits(fill_val);
        eff_mask = rot_byte & pix_mask;
      end
      default:         wm_out = '0;
    endcase
    case (alu_fn)
      ALU_COPY: alu_out = wm_out;
      ALU_AND:  alu_out = wm_out & latch_q;
      ALU_OR:   alu_out = wm_out | latch_q;
      ALU_XOR:  alu_out = wm_out ^ latch_q;
      default:  alu_out = wm_out;
    endcase
    wr_word = (rep_byte(eff_mask) & alu_out) | (~rep_byte(eff_mask) & latch_q);
    if (wm == WM_LATCH_COPY) begin
      wr_word = latch_q;
    end
  end

  // Address-derived plane enables and frame-buffer address
  always_comb begin
    if (chain4) begin
      addr_be   = 4'h1 << HOST_ADDR[1:0];
      fb_addr_d = {HOST_ADDR[FB_AW-1:2], 2'b00};
    end else if (oddeven) begin
      addr_be   = HOST_ADDR[0] ? 4'ha : 4'h5;
      fb_addr_d = {HOST_ADDR[FB_AW-1:1], page_bit};
    end else begin
      addr_be   = 4'hf;
      fb_addr_d = HOST_ADDR;
    end
  end

  // Read datapath
  logic [1:0] rd_plane;
  logic [7:0] cmp_byte;

  always_comb begin
    if (chain4) begin
      rd_plane = HOST_ADDR[1:0];
    end else if (oddeven) begin
      rd_plane = {rpc[1], HOST_ADDR[0]};
    end else begin
      rd_plane = rpc;
    end
    for (int n = 0; n < 8; n++) begin
      cmp_byte[n] = &(~({FB_RDATA[24+n], FB_RDATA[16+n], FB_RDATA[8+n], FB_RDATA[n]} ^
                        match_col) | match_ign);
    end
  end

  // Host sequencing
  // Host address is sampled only at the take edge; it may change afterwards
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:    if (host_take) state_q <= HOST_WE ? ST_WR_REQ : ST_RD_REQ;
        ST_WR_REQ:  if (FB_GNT) state_q <= ST_IDLE;
        ST_RD_REQ:  if (FB_GNT) state_q <= ST_RD_WAIT;
        ST_RD_WAIT: if (FB_RVALID) state_q <= ST_IDLE;
        default:    state_q <= ST_IDLE;
      endcase
    end
  end

  logic [1:0] rd_plane_q;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      fb_req_q   <= 1'b0;
      fb_we_q    <= 1'b0;
      fb_addr_q  <= '0;
      fb_be_q    <= 4'h0;
      fb_wdata_q <= '0;
      rd_plane_q <= 2'h0;
    end else if (host_take) begin
      fb_req_q   <= 1'b1;
      fb_we_q    <= HOST_WE;
      fb_addr_q  <= fb_addr_d;
      rd_plane_q <= rd_plane;
      fb_be_q    <= HOST_WE ? (addr_be & pwe) : 4'hf;
      fb_wdata_q <= HOST_WE ? wr_word : 32'h0;
    end else if (FB_GNT) begin
      fb_req_q <= 1'b0;
    end
  end

  assign FB_REQ   = fb_req_q;
  assign FB_WE    = fb_we_q;
  assign FB_ADDR  = fb_addr_q;
  assign FB_BE    = fb_be_q;
  assign FB_WDATA = fb_wdata_q;

  logic [7:0] rd_sel;
  assign rd_sel = rm ? cmp_byte : FB_RDATA[8*rd_plane_q +: 8];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      latch_q       <= '0;
      host_rdata_q  <= 8'h0;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= 1'b0;
      if (state_q == ST_RD_WAIT && FB_RVALID) begin
        latch_q       <= FB_RDATA;
        host_rdata_q  <= rd_sel;
        host_rvalid_q <= 1'b1;
      end
    end
  end

  assign HOST_RDATA  = host_rdata_q;
  assign HOST_RVALID = host_rvalid_q;

  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic       rd_ret;
  logic [7:0] rot_ref;
  assign rd_ret  = (state_q == ST_RD_WAIT) && FB_RVALID;
  assign rot_ref = 8'((HOST_WDATA >> rot_amt) | (HOST_WDATA << (4'd8 - {1'b0, rot_amt})));

  sequence s_wr_take;
    host_take && HOST_WE;
  endsequence
  sequence s_fb_wr;
    FB_REQ && FB_WE;
  endsequence

  property p_rotate;
    s_wr_take and (wm == WM_FILL_OR_HOST && fill_sel == 4'h0 && alu_fn == ALU_COPY &&
                   pix_mask == 8'hff) |=> FB_WDATA == rep_byte($past(rot_ref));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotated byte not written");

  property p_latch_load;
    rd_ret |=> latch_q == $past(FB_RDATA) && HOST_RVALID ##1 !HOST_RVALID;
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch not loaded");

  property p_mode1;
    s_wr_take and (wm == WM_LATCH_COPY) |=> s_fb_wr and (FB_WDATA == latch_q);
  endproperty
  a_mode1: assert property (p_mode1) else $error("mode 1 altered latch data");

  property p_mode2;
    s_wr_take and (wm == WM_COLOR && alu_fn == ALU_COPY && pix_mask == 8'hff) |=>
      FB_WDATA[7:0] == {8{$past(HOST_WDATA[0])}} && FB_WDATA[31:24] == {8{$past(HOST_WDATA[3])}};
  endproperty
  a_mode2: assert property (p_mode2) else $error("mode 2 replication wrong");

  property p_mask_zero;
    s_wr_take and (pix_mask == 8'h00 && alu_fn == ALU_COPY) |=> FB_WDATA == latch_q;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("zero mask did not copy latch");

  property p_plane_read;
    rd_ret && !rm |=> HOST_RDATA == 8'($past(FB_RDATA) >> {$past(rd_plane_q), 3'b000});
  endproperty
  a_plane_read: assert property (p_plane_read) else $error("wrong plane returned");

  property p_ignore_all;
    rd_ret && rm && match_ign == 4'hf |=> HOST_RDATA == 8'hff;
  endproperty
  a_ignore_all: assert property (p_ignore_all) else $error("ignored planes mismatched");

  property p_enables;
    FB_REQ && FB_WE |-> (FB_BE & ~pwe) == 4'h0;
  endproperty
  a_enables: assert property (p_enables) else $error("disabled plane written");

  property p_one_write;
    s_wr_take |=> s_fb_wr and (!FB_GNT |=> FB_REQ && $stable(FB_WDATA) && $stable(FB_ADDR));
  endproperty
  a_one_write: assert property (p_one_write) else $error("write request not held");

endmodule
`default_nettype wire

// *** testbench/fb_mem_model.sv ***
// Four-plane frame-buffer memory partner with optional grant stall
`default_nettype none
module fb_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  input  wire logic        slow,
  output logic             gnt,
  output logic             rvalid,
  output logic [31:0]      rdata,
  output logic [31:0]      last_wdata,
  output logic [3:0]       last_be
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [256];
  logic [1:0]  wait_q;
  // Slow mode stalls two cycles so the request must be held
  assign gnt = req && (!slow || wait_q == 2'h2);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 2'h0;
    end else begin
      wait_q <= (req && !gnt) ? wait_q + 2'h1 : 2'h0;
    end
  end
  always @(posedge clk) begin
    if (req && gnt && we) begin
      for (int b = 0; b < 4; b++) begin
        if (be[b]) mem[addr[7:0]][8*b+:8] <= wdata[8*b+:8];
      end
      last_wdata <= wdata;
      last_be <= be;
    end
  end
  // Stale data is inverted every cycle so it never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
    end else if (req && gnt && !we) begin
      rvalid <= 1'b1;
      rdata <= mem[addr[7:0]];
    end else begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule
`default_nettype wire

// *** testbench/vga_plane_rw_datapath_test.sv ***
// Self-checking bench for the byte-to-plane datapath
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module vga_plane_rw_datapath_test
  import vga_rw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Entry: mode, rot, fill, mask(16), host byte
  localparam logic [47:0] WT [8] = '{48'h00_03_51_0fff_b4, 48'h00_0f_00_053c_96,
    48'h01_19_00_0f5a_3c, 48'h02_15_00_0f0f_09, 48'h03_1a_0a_0f77_e1, 48'h00_00_00_0f00_5d,
    48'h00_05_00_0fff_b4, 48'h02_00_00_0fff_0a};
  logic        MCLK = 1'b0, RST = 1'b1, slow = 1'b0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        HOST_REQ = 1'b0, HOST_WE = 1'b0;
  logic [7:0]  AWADDR = 8'h0, ARADDR = 8'h0, HOST_WDATA = 8'h0, HOST_RDATA, hr_q;
  logic [31:0] WDATA = 32'h0, RDATA, FB_WDATA, FB_RDATA, last_wdata, w;
  logic [3:0]  WSTRB = 4'h0, FB_BE, last_be;
  logic [15:0] HOST_ADDR = 16'h0, FB_ADDR;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, HOST_READY, HOST_RVALID;
  logic        FB_REQ, FB_WE, FB_GNT, FB_RVALID;
  logic [1:0]  BRESP, RRESP;
  logic [47:0] e;
  int          n_errors = 0, n_tests = 0;

  always #2.5 MCLK = ~MCLK;

  vga_plane_rw_datapath dut (.MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
    .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .HOST_REQ, .HOST_WE, .HOST_ADDR, .HOST_WDATA, .HOST_READY, .HOST_RDATA,
    .HOST_RVALID, .FB_REQ, .FB_WE, .FB_ADDR, .FB_BE, .FB_WDATA, .FB_GNT, .FB_RVALID, .FB_RDATA);
  fb_mem_model fbm (.clk(MCLK), .rst(RST), .req(FB_REQ), .we(FB_WE), .addr(FB_ADDR),
    .be(FB_BE), .wdata(FB_WDATA), .slow, .gnt(FB_GNT), .rvalid(FB_RVALID), .rdata(FB_RDATA),
    .last_wdata, .last_be);

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] handshake expected 1 seen 0");
      stop_test();
    end
  endtask

  function automatic logic [31:0] fbw(input int i);
    return (i == 8) ? 32'h0f0f_f0f0 : 32'h9c3a_61f5 + 32'(i) * 32'h0f0f_1e1e;
  endfunction

  function automatic logic [31:0] exp_w(input logic [47:0] t, input logic [31:0] lat);
    logic [7:0]  rh, pm;
    logic [31:0] u, a;
    rh = (t[7:0] >> t[34:32]) | (t[7:0] << (4'd8 - t[34:32]));
    for (int b = 0; b < 4; b++) begin
      case (t[41:40])
        WM_FILL_OR_HOST: u[8*b+:8] = t[28+b] ? {8{t[24+b]}} : rh;
        WM_LATCH_COPY:   u[8*b+:8] = lat[8*b+:8];
        WM_COLOR:        u[8*b+:8] = {8{t[b]}};
        default:         u[8*b+:8] = {8{t[24+b]}};
      endcase
    end
    pm = (t[41:40] == WM_FILL_MASKED) ? (rh & t[15:8]) : t[15:8];
    case (t[36:35])
      ALU_COPY: a = u;
      ALU_AND:  a = u & lat;
      ALU_OR:   a = u | lat;
      default:  a = u ^ lat;
    endcase
    return (t[41:40] == WM_LATCH_COPY) ? lat : ((a & {4{pm}}) | (lat & ~{4{pm}}));
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic       ah, wh, bh;
    logic [1:0] rs;
    int         n;
    ah = 1'b0;
    wh = 1'b0;
    bh = 1'b0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 64 && !(ah && wh); n++) begin
      @(negedge MCLK);
      ah |= AWREADY;
      wh |= WREADY;
      @(posedge MCLK);
      AWVALID <= !ah;
      WVALID <= !wh;
    end
    for (n = 0; n < 64 && !bh; n++) begin
      @(negedge MCLK);
      bh = BVALID;
      rs = BRESP;
      @(posedge MCLK);
    end
    BREADY <= 1'b0;
    hang(bh);
    `CHK("bresp", er, rs)
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic        ah, got;
    logic [1:0]  rs;
    logic [31:0] rd;
    int          n;
    ah = 1'b0;
    got = 1'b0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 64 && !got; n++) begin
      @(negedge MCLK);
      ah |= ARREADY;
      got = RVALID;
      rd = RDATA;
      rs = RRESP;
      @(posedge MCLK);
      ARVALID <= !ah;
    end
    RREADY <= 1'b0;
    hang(got);
    `CHK("rdata", ed, rd)
    `CHK("rresp", er, rs)
  endtask

  task automatic host_op(input logic we, input logic [15:0] a, input logic [7:0] d);
    logic th, dn;
    int   n;
    th = 1'b0;
    dn = 1'b0;
    @(posedge MCLK);
    HOST_REQ <= 1'b1;
    HOST_WE <= we;
    HOST_ADDR <= a;
    HOST_WDATA <= d;
    for (n = 0; n < 64 && !dn; n++) begin
      @(negedge MCLK);
      dn = th && (we ? HOST_READY : HOST_RVALID);
      if (HOST_RVALID) hr_q = HOST_RDATA;
      th |= HOST_READY;
      @(posedge MCLK);
      HOST_REQ <= !th;
    end
    hang(dn);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) fbm.mem[i] = fbw(i);
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    axi_rd(OFF_MODE, RST_MODE, RESP_OKAY);
    axi_rd(OFF_FILL, RST_FILL, RESP_OKAY);
    axi_rd(OFF_MASK, RST_MASK, RESP_OKAY);
    axi_rd(OFF_MATCH, RST_MATCH, RESP_OKAY);
    axi_rd(OFF_LATCH, 32'h0, RESP_OKAY);
    axi_rd(8'h1c, 32'h0, RESP_SLVERR);
    axi_wr(OFF_LATCH, 32'h1, RESP_SLVERR);
    axi_wr(OFF_ROT, 32'hffff_ffff, RESP_OKAY);
    axi_rd(OFF_ROT, WMASK_ROT, RESP_OKAY);
    $display("test registers done");
    w = fbw(4);
    for (int p = 0; p < 4; p++) begin
      axi_wr(OFF_MATCH, 32'(p << MATCH_RPC_LSB), RESP_OKAY);
      host_op(1'b0, 16'h4, 8'h0);
      `CHK("rd_plane", w[8*p+:8], hr_q)
    end
    axi_rd(OFF_LATCH, w, RESP_OKAY);
    axi_wr(OFF_MODE, 32'h8, RESP_OKAY);
    axi_wr(OFF_MATCH, 32'h0, RESP_OKAY);
    host_op(1'b0, 16'h6, 8'h0);
    `CHK("rd_interleave", w[23:16], hr_q)
    axi_wr(OFF_MODE, 32'h10, RESP_OKAY);
    axi_wr(OFF_MATCH, 32'h200, RESP_OKAY);
    host_op(1'b0, 16'h5, 8'h0);
    `CHK("rd_oddeven", w[31:24], hr_q)
    $display("test read mode 0 done");
    axi_wr(OFF_MODE, 32'h4, RESP_OKAY);
    axi_wr(OFF_MATCH, 32'h3, RESP_OKAY);
    host_op(1'b0, 16'h8, 8'h0);
    `CHK("rd_compare", 8'hf0, hr_q)
    axi_wr(OFF_MATCH, 32'h3f, RESP_OKAY);
    host_op(1'b0, 16'h8, 8'h0);
    `CHK("rd_ignore", 8'h0f, hr_q)
    axi_wr(OFF_MATCH, 32'hf0, RESP_OKAY);
    host_op(1'b0, 16'h8, 8'h0);
    `CHK("rd_ignore_all", 8'hff, hr_q)
    $display("test read mode 1 done");
    for (int i = 0; i < 8; i++) begin
      e = WT[i];
      slow <= i[0];
      axi_wr(OFF_MODE, {24'h0, e[47:40]}, RESP_OKAY);
      axi_wr(OFF_ROT, {24'h0, e[39:32]}, RESP_OKAY);
      axi_wr(OFF_FILL, {24'h0, e[31:24]}, RESP_OKAY);
      axi_wr(OFF_MASK, {16'h0, e[23:8]}, RESP_OKAY);
      host_op(1'b0, 16'(12 + i), 8'h0);
      host_op(1'b1, 16'(12 + i), e[7:0]);
      `CHK("wr_word", exp_w(e, fbw(12 + i)), last_wdata)
      `CHK("wr_alu", exp_w(e, fbw(12 + i)), last_wdata)
      `CHK("wr_latch", exp_w(e, fbw(12 + i)), last_wdata)
      `CHK("wr_be", e[19:16], last_be)
    end
    $display("test write path done");
    w = fbw(19);
    axi_rd(OFF_STATUS, {23'h0, w[7:0], 1'b0}, RESP_OKAY);
    axi_wr(OFF_MODE, 32'h8, RESP_OKAY);
    host_op(1'b1, 16'h26, 8'h3c);
    `CHK("wr_chain4", (fbw(36) & 32'hff00_ffff) | 32'h003c_0000, fbm.mem[36])
    axi_wr(OFF_MODE, 32'h30, RESP_OKAY);
    host_op(1'b1, 16'h2a, 8'h3c);
    `CHK("wr_oddeven", (fbw(43) & 32'hff00_ff00) | 32'h003c_003c, fbm.mem[43])
    $display("test write addressing done");
    stop_test();
  end
endmodule
`default_nettype wire
